/* File: core/dmx_regs.vh */
// constants for the data-move instruction executor
// Functional notes
// - pointer load: high nibble first, low byte second
// - pointer load decoded as two words, two cycles
// - register move decode, copies, sets negative/zero
// - destination bit 0 to W, 1 back to register
// - bank bit 0 access bank, 1 bank select
// - 8-bit address reaches whole 256-byte bank
// - extended set, bank bit 0, f<=5Fh indexed offset
// - file move spans 4096 bytes, flags untouched
// - file move: opcode 1100 then 1111, two cycles
// - working register may be source or destination
`ifndef DMX_REGS_VH
`define DMX_REGS_VH

// four-phase instruction cycle
`define DMX_PH_Q1        2'h0
`define DMX_PH_Q2        2'h1
`define DMX_PH_Q3        2'h2
`define DMX_PH_Q4        2'h3

// opcode prefixes
`define DMX_OP_PTR_LOAD  6'h38
`define DMX_OP_REG_MOVE  6'h14
`define DMX_OP_FILE_MOVE 4'hc
`define DMX_OP_SECOND    4'hf
`define DMX_OP_PTR_LOW   8'hf0

// address mapping
`define DMX_IDX_LIMIT    8'h5f
`define DMX_ACC_HI_BANK  4'hf
`define DMX_PTR_LAST     2'h2
`define DMX_PTR_IDX      2'h2

// reset values
`define DMX_BYTE_RST     8'h00
`define DMX_ADDR_RST     12'h000
`define DMX_NIB_RST      4'h0

`endif

/* File: core/dmx_ptr_file.v */
// three 12-bit indirect pointers written high nibble first, then low byte
`timescale 1ns/1ns
`include "dmx_regs.vh"
module dmx_ptr_file #(
   parameter PTR_W = 12
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             hi_we_i,
   input  wire             lo_we_i,
   input  wire [1:0]       sel_i,
   input  wire [3:0]       hi_i,
   input  wire [7:0]       lo_i,
   output reg  [PTR_W-1:0] ptr0_o,
   output reg  [PTR_W-1:0] ptr1_o,
   output reg  [PTR_W-1:0] ptr2_o
);

// high nibble and low byte arrive in separate instruction cycles
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      ptr0_o <= `DMX_ADDR_RST;
      ptr1_o <= `DMX_ADDR_RST;
      ptr2_o <= `DMX_ADDR_RST;
   end else begin
      if (hi_we_i) begin
         case (sel_i)
            2'h0:    ptr0_o[11:8] <= hi_i;
            2'h1:    ptr1_o[11:8] <= hi_i;
            2'h2:    ptr2_o[11:8] <= hi_i;
            default: ptr2_o       <= ptr2_o; // selector 3 names none
         endcase
      end
      if (lo_we_i) begin
         case (sel_i)
            2'h0:    ptr0_o[7:0] <= lo_i;
            2'h1:    ptr1_o[7:0] <= lo_i;
            2'h2:    ptr2_o[7:0] <= lo_i;
            default: ptr2_o      <= ptr2_o;
         endcase
      end
   end
end

endmodule // dmx_ptr_file

/* File: core/dmx_addr_map.v */
// maps an 8-bit banked register address onto the 12-bit data space
`timescale 1ns/1ns
`include "dmx_regs.vh"
module dmx_addr_map #(
   parameter [7:0] ACC_SPLIT = 8'h80
) (
   input  wire [7:0]  f_i,
   input  wire        bank_bit_i,
   input  wire        ext_en_i,
   input  wire [3:0]  bank_sel_i,
   input  wire [11:0] ptr_idx_i,
   output reg  [11:0] addr_o
);

// indexed mode wins over the plain access bank in its low window
always @* begin
   if (bank_bit_i) begin
      addr_o = {bank_sel_i, f_i};
   end else if (ext_en_i && (f_i <= `DMX_IDX_LIMIT)) begin
      addr_o = ptr_idx_i + {4'h0, f_i};
   end else if (f_i < ACC_SPLIT) begin
      addr_o = {4'h0, f_i};
   end else begin
      addr_o = {`DMX_ACC_HI_BANK, f_i};
   end
end

endmodule // dmx_addr_map

/* File: core/dmx_exec.v */
// executes pointer load, register move and file-to-file move
`timescale 1ns/1ns
`include "dmx_regs.vh"
module dmx_exec #(
   parameter [11:0] WREG_ADDR = 12'hfe8,
   parameter [7:0]  ACC_SPLIT = 8'h80
) (
   input  wire        CLK_SYS_I,
   input  wire        RST_N_I,
   input  wire [15:0] INSTR_I,
   input  wire        INSTR_VALID_I,
   input  wire [3:0]  BANK_SEL_I,
   input  wire        EXT_SET_EN_I,
   input  wire [7:0]  MEM_RDATA_I,
   output reg         Q1_O,
   output reg         SECOND_WORD_O,
   output reg         MEM_RD_O,
   output reg         MEM_WR_O,
   output reg  [11:0] MEM_ADDR_O,
   output reg  [7:0]  MEM_WDATA_O,
   output reg  [7:0]  W_O,
   output reg         FLAG_N_O,
   output reg         FLAG_Z_O,
   output reg         FLAGS_UPD_O,
   output wire [11:0] PTR0_O,
   output wire [11:0] PTR1_O,
   output wire [11:0] PTR2_O
);

// sequencer states: which word the next cycle expects
localparam ST_FIRST = 2'h0;
localparam ST_PTR2  = 2'h1;
localparam ST_MOVE2 = 2'h2;

// operation carried by the current instruction cycle
localparam OP_NONE   = 3'h0;
localparam OP_PTR_HI = 3'h1;
localparam OP_PTR_LO = 3'h2;
localparam OP_REGMOV = 3'h3;
localparam OP_F2F_RD = 3'h4;
localparam OP_F2F_WR = 3'h5;

reg  [1:0]  phase_reg;
reg  [1:0]  state_reg;
reg  [2:0]  op_reg;
reg  [1:0]  sel_reg;
reg  [3:0]  hi_reg;
reg  [7:0]  lo_reg;
reg         dest_f_reg;
reg         from_w_reg;
reg         to_w_reg;
reg  [7:0]  hold_reg;
wire [11:0] map_addr;
wire [7:0]  src_data;
wire        ptr_hi_we;
wire        ptr_lo_we;

// true when a 12-bit address names the working register
function is_wreg;
   input [11:0] a;
   begin
      is_wreg = (a == WREG_ADDR);
   end
endfunction

// banked address of the register move, taken from the word in Q1
dmx_addr_map #(
   .ACC_SPLIT  (ACC_SPLIT)
) u_map (
   .f_i        (INSTR_I[7:0]),
   .bank_bit_i (INSTR_I[8]),
   .ext_en_i   (EXT_SET_EN_I),
   .bank_sel_i (BANK_SEL_I),
   .ptr_idx_i  (PTR2_O),
   .addr_o     (map_addr)
);

// pointer bytes land at the end of the process phase
assign ptr_hi_we = (phase_reg == `DMX_PH_Q3) && (op_reg == OP_PTR_HI);
assign ptr_lo_we = (phase_reg == `DMX_PH_Q3) && (op_reg == OP_PTR_LO);

dmx_ptr_file #(
   .PTR_W   (12)
) u_ptr (
   .clk_i   (CLK_SYS_I),
   .rst_n_i (RST_N_I),
   .hi_we_i (ptr_hi_we),
   .lo_we_i (ptr_lo_we),
   .sel_i   (sel_reg),
   .hi_i    (hi_reg),
   .lo_i    (lo_reg),
   .ptr0_o  (PTR0_O),
   .ptr1_o  (PTR1_O),
   .ptr2_o  (PTR2_O)
);

// the working register is held here, so it never goes to memory
assign src_data = from_w_reg ? W_O : MEM_RDATA_I;

// free-running phase counter, one clock per phase
always @(posedge CLK_SYS_I or negedge RST_N_I) begin
   if (!RST_N_I) begin
      phase_reg <= `DMX_PH_Q1;
      Q1_O      <= 1'b1;
   end else begin
      phase_reg <= phase_reg + 2'h1;
      Q1_O      <= (phase_reg == `DMX_PH_Q4);
   end
end

// decode at the end of Q1; reads are issued for Q2
always @(posedge CLK_SYS_I or negedge RST_N_I) begin
   if (!RST_N_I) begin
      state_reg     <= ST_FIRST;
      op_reg        <= OP_NONE;
      sel_reg       <= 2'h0;
      hi_reg        <= `DMX_NIB_RST;
      lo_reg        <= `DMX_BYTE_RST;
      dest_f_reg    <= 1'b0;
      from_w_reg    <= 1'b0;
      to_w_reg      <= 1'b0;
      SECOND_WORD_O <= 1'b0;
      MEM_RD_O      <= 1'b0;
      MEM_ADDR_O    <= `DMX_ADDR_RST;
   end else if (phase_reg == `DMX_PH_Q1) begin
      op_reg     <= OP_NONE;
      from_w_reg <= 1'b0;
      to_w_reg   <= 1'b0;
      if (INSTR_VALID_I) begin
         case (state_reg)
            ST_FIRST: begin
               if (INSTR_I[15:10] == `DMX_OP_PTR_LOAD) begin
                  op_reg        <= OP_PTR_HI;
                  sel_reg       <= INSTR_I[5:4];
                  hi_reg        <= INSTR_I[3:0];
                  state_reg     <= ST_PTR2;
                  SECOND_WORD_O <= 1'b1;
               end else if (INSTR_I[15:10] == `DMX_OP_REG_MOVE) begin
                  op_reg     <= OP_REGMOV;
                  dest_f_reg <= INSTR_I[9];
                  MEM_ADDR_O <= map_addr;
                  from_w_reg <= is_wreg(map_addr);
                  to_w_reg   <= is_wreg(map_addr);
                  MEM_RD_O   <= !is_wreg(map_addr);
               end else if (INSTR_I[15:12] == `DMX_OP_FILE_MOVE) begin
                  op_reg        <= OP_F2F_RD;
                  MEM_ADDR_O    <= INSTR_I[11:0];
                  from_w_reg    <= is_wreg(INSTR_I[11:0]);
                  MEM_RD_O      <= !is_wreg(INSTR_I[11:0]);
                  state_reg     <= ST_MOVE2;
                  SECOND_WORD_O <= 1'b1;
               end else begin
                  // lone second words and foreign opcodes do nothing
                  op_reg <= OP_NONE;
               end
            end
            ST_PTR2: begin
               // the low byte is taken whatever the prefix says
               op_reg        <= OP_PTR_LO;
               lo_reg        <= INSTR_I[7:0];
               state_reg     <= ST_FIRST;
               SECOND_WORD_O <= 1'b0;
            end
            ST_MOVE2: begin
               // destination word: no read strobe this cycle
               op_reg        <= OP_F2F_WR;
               MEM_ADDR_O    <= INSTR_I[11:0];
               to_w_reg      <= is_wreg(INSTR_I[11:0]);
               state_reg     <= ST_FIRST;
               SECOND_WORD_O <= 1'b0;
            end
            default: begin
               state_reg     <= ST_FIRST;
               SECOND_WORD_O <= 1'b0;
            end
         endcase
      end
   end else if (phase_reg == `DMX_PH_Q2) begin
      MEM_RD_O <= 1'b0; // read strobe lasts the Q2 phase only
   end
end

// process at the end of Q3; writes show during Q4
always @(posedge CLK_SYS_I or negedge RST_N_I) begin
   if (!RST_N_I) begin
      hold_reg    <= `DMX_BYTE_RST;
      W_O         <= `DMX_BYTE_RST;
      FLAG_N_O    <= 1'b0;
      FLAG_Z_O    <= 1'b0;
      FLAGS_UPD_O <= 1'b0;
      MEM_WR_O    <= 1'b0;
      MEM_WDATA_O <= `DMX_BYTE_RST;
   end else if (phase_reg == `DMX_PH_Q3) begin
      case (op_reg)
         OP_REGMOV: begin
            FLAG_N_O    <= src_data[7];
            FLAG_Z_O    <= (src_data == `DMX_BYTE_RST);
            FLAGS_UPD_O <= 1'b1;
            if (!dest_f_reg || to_w_reg) begin
               W_O <= src_data;
            end else begin
               MEM_WR_O    <= 1'b1;
               MEM_WDATA_O <= src_data;
            end
         end
         OP_F2F_RD: begin
            hold_reg <= src_data;
         end
         OP_F2F_WR: begin
            // flags stay as they were for the file move
            if (to_w_reg) begin
               W_O <= hold_reg;
            end else begin
               MEM_WR_O    <= 1'b1;
               MEM_WDATA_O <= hold_reg;
            end
         end
         default: begin
            MEM_WR_O <= 1'b0;
         end
      endcase
   end else begin
      // write strobe and flag pulse end with Q4
      MEM_WR_O    <= 1'b0;
      FLAGS_UPD_O <= 1'b0;
   end
end

endmodule // dmx_exec

/* File: bench/dmx_exec_properties.sv */
// port assertions for the data-move instruction executor
`timescale 1ns/1ns
module dmx_exec_props #(
   parameter [11:0] WREG_ADDR = 12'hfe8
) (
   input wire        CLK_SYS_I,
   input wire        RST_N_I,
   input wire [15:0] INSTR_I,
   input wire        INSTR_VALID_I,
   input wire [3:0]  BANK_SEL_I,
   input wire        Q1_O,
   input wire        SECOND_WORD_O,
   input wire        MEM_RD_O,
   input wire        MEM_WR_O,
   input wire [11:0] MEM_ADDR_O,
   input wire [7:0]  MEM_WDATA_O,
   input wire [7:0]  W_O,
   input wire        FLAG_N_O,
   input wire        FLAG_Z_O,
   input wire        FLAGS_UPD_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   // moved value is on the write bus, or in w when no strobe is made
   wire        tk = Q1_O && INSTR_VALID_I;
   wire        fw = tk && !SECOND_WORD_O;
   wire [11:0] lo = INSTR_I[11:0];
   wire [11:0] ba = {BANK_SEL_I, INSTR_I[7:0]};
   wire [7:0]  mv = MEM_WR_O ? MEM_WDATA_O : W_O;
   sequence s_fm1;
      fw && INSTR_I[15:12] == 4'hc;
   endsequence
   sequence s_fm2;
      tk && lo != WREG_ADDR;
   endsequence
   // q1 is held high through reset, so only a rising edge opens a period
   chk_q1_period: assert property
      ($rose(Q1_O) |=> !Q1_O [*3] ##1 Q1_O)
      else $error("q1 phase period wrong");
   chk_rd_in_q2: assert property (MEM_RD_O |-> $past(Q1_O))
      else $error("read strobe outside q2");
   chk_wr_in_q4: assert property (MEM_WR_O |-> $past(Q1_O, 3))
      else $error("write strobe outside q4");
   chk_flags_hold: assert property
      (!FLAGS_UPD_O |-> $stable({FLAG_N_O, FLAG_Z_O}))
      else $error("flags moved without update");
   chk_flag_value: assert property (FLAGS_UPD_O |->
      FLAG_Z_O == (mv == 8'h00) && FLAG_N_O == mv[7])
      else $error("flags disagree with moved value");
   chk_ptr_second: assert property
      (fw && INSTR_I[15:10] == 6'h38 |=> SECOND_WORD_O)
      else $error("pointer load not waiting for word two");
   chk_fm_noread: assert property (s_fm1 ##4 s_fm2 |=>
      !MEM_RD_O && MEM_ADDR_O == $past(lo))
      else $error("file move second cycle wrong");
   chk_fm_write: assert property (s_fm1 ##4 s_fm2 |-> ##3 MEM_WR_O)
      else $error("file move did not write");
   chk_lone_nop: assert property (fw && INSTR_I[15:12] == 4'hf |=>
      !MEM_RD_O ##2 !MEM_WR_O && !FLAGS_UPD_O)
      else $error("lone second word acted");
   chk_bank_addr: assert property (fw && INSTR_I[15:10] == 6'h14 &&
      INSTR_I[8] && ba != WREG_ADDR |=> MEM_RD_O && MEM_ADDR_O == $past(ba))
      else $error("banked address wrong");
endmodule // dmx_exec_props
bind dmx_exec dmx_exec_props #(.WREG_ADDR(WREG_ADDR)) u_props (
   .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .INSTR_I(INSTR_I),
   .INSTR_VALID_I(INSTR_VALID_I), .BANK_SEL_I(BANK_SEL_I), .Q1_O(Q1_O),
   .SECOND_WORD_O(SECOND_WORD_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
   .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .W_O(W_O),
   .FLAG_N_O(FLAG_N_O), .FLAG_Z_O(FLAG_Z_O), .FLAGS_UPD_O(FLAGS_UPD_O));

/* File: bench/dmx_mem_model.sv */
// data memory partner: read data steady in q3, write at end of q4
`timescale 1ns/1ns
module dmx_mem_model (
   input  wire        clk_i,
   input  wire        rd_i,
   input  wire        wr_i,
   input  wire [11:0] addr_i,
   input  wire [7:0]  wdata_i,
   output reg  [7:0]  rdata_o = 8'h00
);
   reg [7:0] mem [0:4095];
   // outside a read the bus toggles, so stale data never looks valid
   always @(posedge clk_i) begin
      rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
      if (wr_i)
         mem[addr_i] <= wdata_i;
   end
endmodule // dmx_mem_model

/* File: bench/dmx_exec_tb_top.sv */
// self-checking bench for the data-move instruction executor
`timescale 1ns/1ns
module dmx_exec_tb_top;
   localparam [11:0] WREG = 12'hfe8;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [15:0] instr = 16'h0000;
   reg         vld = 1'b0;
   reg  [3:0]  bsel = 4'h0;
   reg         ext = 1'b0;
   reg  [1:0]  ph = 2'h0;
   reg  [11:0] pv [0:2];
   integer     miscompares = 0;
   integer     samples_checked = 0;
   wire        q1, sw, rd, wr, fn, fz, fu;
   wire [11:0] addr, p0, p1, p2;
   wire [7:0]  rdata, wdata, w;
   always #2 clk = ~clk;
   // own phase count, so words are driven at the edge opening q1
   always @(posedge clk or negedge rst_n)
      if (!rst_n) ph <= 2'h0;
      else ph <= ph + 2'h1;
   dmx_exec uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .INSTR_I(instr),
      .INSTR_VALID_I(vld), .BANK_SEL_I(bsel), .EXT_SET_EN_I(ext),
      .MEM_RDATA_I(rdata), .Q1_O(q1), .SECOND_WORD_O(sw), .MEM_RD_O(rd),
      .MEM_WR_O(wr), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .W_O(w),
      .FLAG_N_O(fn), .FLAG_Z_O(fz), .FLAGS_UPD_O(fu), .PTR0_O(p0),
      .PTR1_O(p1), .PTR2_O(p2));
   dmx_mem_model u_mem (.clk_i(clk), .rd_i(rd), .wr_i(wr), .addr_i(addr),
      .wdata_i(wdata), .rdata_o(rdata));
   task close_out;
      begin
         if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task check(input [11:0] seen, input [11:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // bounded wait for the q1 opening edge, then one word is taken
   task issue(input [15:0] word);
      integer n;
      begin
         n = 0;
         @(posedge clk);
         while (ph !== 2'h3 && n < 8) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n == 8) begin
            miscompares = miscompares + 1;
            close_out;
         end
         instr <= word;
         vld <= 1'b1;
         @(posedge clk);
         vld <= 1'b0;
      end
   endtask
   // selector 3 must leave every pointer alone
   task s_ptr;
      integer s;
      reg [11:0] k;
      begin
         pv[0] = 12'h000;
         pv[1] = 12'h000;
         pv[2] = 12'h000;
         for (s = 0; s < 4; s = s + 1) begin
            k = 12'h3a8 + s;
            issue({6'h38, 4'h0, s[1:0], k[11:8]});
            @(negedge clk) check(sw, 1'b1);
            issue({8'hf0, k[7:0]});
            repeat (3) @(negedge clk);
            if (s < 3)
               pv[s] = k;
            check(p0, pv[0]);
            check(p1, pv[1]);
            check(p2, pv[2]);
         end
      end
   endtask
   task s_reg;
      reg [34:0] t [0:5];
      reg        e, a, d;
      reg [3:0]  b;
      reg [7:0]  f, dat;
      reg [11:0] ea;
      integer    i;
      begin
         t[0] = {3'b000, 4'h0, 8'h10, 8'h80, 12'h010};
         t[1] = {3'b011, 4'h3, 8'hff, 8'h00, 12'h3ff};
         t[2] = {3'b000, 4'h0, 8'h90, 8'h7f, 12'hf90};
         t[3] = {3'b100, 4'h0, 8'h5f, 8'h01, pv[2] + 12'h05f};
         t[4] = {3'b101, 4'h0, 8'h60, 8'h44, 12'h060};
         // banked address naming w: no strobe, w moves onto itself
         t[5] = {3'b010, 4'hf, 8'he8, 8'h01, WREG};
         for (i = 0; i < 6; i = i + 1) begin
            {e, a, d, b, f, dat, ea} = t[i];
            u_mem.mem[ea] = dat;
            @(posedge clk);
            ext <= e;
            bsel <= b;
            issue({6'h14, d, a, f});
            @(negedge clk) check(addr, ea);
            check(rd, ea != WREG);
            repeat (2) @(negedge clk);
            check(d ? wdata : w, dat);
            check(wr, d);
            check({fn, fz}, {dat[7], dat == 8'h00});
         end
      end
   endtask
   // words go back to back; never counter-low or stack-top as dst
   task s_fm(input [11:0] src, input [11:0] dst, input [7:0] exp);
      begin
         issue({4'hc, src});
         @(negedge clk) check(rd, src != WREG);
         if (src != WREG)
            check(addr, src);
         issue({4'hf, dst});
         @(negedge clk) check(rd, 1'b0);
         repeat (2) @(negedge clk);
         check(wr, dst != WREG);
         check(dst == WREG ? w : wdata, exp);
         if (dst != WREG)
            check(addr, dst);
      end
   endtask
   task s_lone;
      begin
         issue(16'hf123);
         @(negedge clk) check(rd, 1'b0);
         repeat (2) @(negedge clk);
         check({wr, fu}, 2'b00);
         check(w, 8'h3c);
      end
   endtask
   // reset in mid-run, then the first word after release must be taken
   task s_rst;
      begin
         @(posedge clk);
         rst_n <= 1'b0;
         repeat (2) @(posedge clk);
         @(negedge clk) check({q1, sw, rd, wr, fu}, 5'b10000);
         check(w, 8'h00);
         check(p2, 12'h000);
         @(posedge clk);
         rst_n <= 1'b1;
         issue(16'h5010);
         @(negedge clk) check(addr, 12'h010);
         repeat (2) @(negedge clk);
         check(w, 8'h80);
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      s_ptr;
      s_reg;
      u_mem.mem[12'h123] = 8'h5a;
      u_mem.mem[12'hfff] = 8'h3c;
      s_fm(12'h123, 12'habc, 8'h5a);
      s_fm(12'hfff, WREG, 8'h3c);
      s_fm(WREG, 12'h000, 8'h3c);
      s_lone;
      s_rst;
      close_out;
   end
endmodule // dmx_exec_tb_top
